// File: rtl/gpfp_port.sv
// gpio port top: wishbone slave, single-cycle core port alias, pin drive
`timescale 1ns/1ps
module gpfp_port #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // classic wishbone slave (system bus view)
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [7:0]       adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    output logic                  ack_o,
    output logic                  err_o,
    // single-cycle core port
    input  wire logic             cp_sel_i,
    input  wire logic             cp_we_i,
    input  wire logic [31:0]      cp_addr_i,
    input  wire logic [31:0]      cp_wdata_i,
    output logic      [31:0]      cp_rdata_o,
    output logic                  cp_hit_o,
    // system state
    input  wire logic             compute_only_i,
    input  wire logic             port_ctrl_en_i,
    input  wire logic [WIDTH-1:0] gpio_func_i,
    // pins
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] pin_o,
    output logic      [WIDTH-1:0] pin_oe_o
);
    // --------------------------------------------------------
    // elaboration check
    // --------------------------------------------------------
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("gpfp_port: WIDTH must be 1..32");
    end

    logic [WIDTH-1:0] pin_m_q, pin_s_q;
    logic [WIDTH-1:0] latch, dir, indata;
    logic [WIDTH-1:0] sample_en;
    logic             cp_hit, bus_req, bus_ok, bus_grant;
    logic             reg_we;
    logic [7:0]       reg_ofs;
    logic [31:0]      reg_wdat;
    logic [31:0]      bus_wmask;
    logic             ack_q, ack_d;
    logic             err_q, err_d;
    logic [31:0]      bdat_q, bdat_d;
    logic [31:0]      cpdat_q, cpdat_d;

    // --------------------------------------------------------
    // pin synchroniser, two flops
    // --------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_m_q <= '0;
            pin_s_q <= '0;
        end else begin
            pin_m_q <= pin_i;
            pin_s_q <= pin_m_q;
        end
    end

    // sampling runs only with port control clocked and out of compute-only
    assign sample_en = {WIDTH{port_ctrl_en_i & ~compute_only_i}};

    // --------------------------------------------------------
    // decode and arbitration
    // --------------------------------------------------------
    function automatic logic ofs_mapped(input logic [7:0] o);
        ofs_mapped = (o == gpfp_pkg::OFS_OUT_LATCH) || (o == gpfp_pkg::OFS_OUT_SET)
                  || (o == gpfp_pkg::OFS_OUT_CLR) || (o == gpfp_pkg::OFS_OUT_TGL)
                  || (o == gpfp_pkg::OFS_IN_DATA) || (o == gpfp_pkg::OFS_DIR);
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] o,
                                              input logic [WIDTH-1:0] l,
                                              input logic [WIDTH-1:0] d,
                                              input logic [WIDTH-1:0] i);
        read_word = 32'h0000_0000; // set/clear/toggle read zero
        if (o == gpfp_pkg::OFS_OUT_LATCH) read_word[WIDTH-1:0] = l;
        if (o == gpfp_pkg::OFS_DIR)       read_word[WIDTH-1:0] = d;
        if (o == gpfp_pkg::OFS_IN_DATA)   read_word[WIDTH-1:0] = i;
    endfunction

    assign cp_hit = cp_sel_i
        && ((cp_addr_i & gpfp_pkg::CORE_PORT_MASK) == gpfp_pkg::CORE_PORT_BASE);
    assign bus_req   = cyc_i && stb_i && !ack_q && !err_q;
    assign bus_ok    = !compute_only_i && ofs_mapped(adr_i);
    assign bus_grant = bus_req && bus_ok && !cp_hit;

    // byte lanes of the bus write
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            bus_wmask[8*b +: 8] = {8{sel_i[b]}};
        end
    end

    // one shared write port: core port first, then bus
    always_comb begin
        reg_we   = 1'b0;
        reg_ofs  = adr_i;
        reg_wdat = 32'h0000_0000;
        if (cp_hit) begin
            reg_we   = cp_we_i;
            reg_ofs  = cp_addr_i[7:0];
            reg_wdat = cp_wdata_i;
        end else if (bus_grant && we_i) begin
            reg_we  = 1'b1;
            reg_ofs = adr_i;
            // partial writes merge with the latch/dir image; strobes use zero lanes
            if (adr_i == gpfp_pkg::OFS_OUT_LATCH) begin
                reg_wdat = (dat_i & bus_wmask) | ({{(32-WIDTH){1'b0}}, latch} & ~bus_wmask);
            end else if (adr_i == gpfp_pkg::OFS_DIR) begin
                reg_wdat = (dat_i & bus_wmask) | ({{(32-WIDTH){1'b0}}, dir} & ~bus_wmask);
            end else begin
                reg_wdat = dat_i & bus_wmask;
            end
        end
    end

    gpfp_regs #(
        .WIDTH (WIDTH)
    ) u_regs (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .we_i        (reg_we),
        .ofs_i       (reg_ofs),
        .wdat_i      (reg_wdat[WIDTH-1:0]),
        .pin_sync_i  (pin_s_q),
        .sample_en_i (sample_en),
        .latch_o     (latch),
        .dir_o       (dir),
        .indata_o    (indata)
    );

    // --------------------------------------------------------
    // answers: bus ack one cycle after grant, err one cycle after a refused request, core data next edge
    // --------------------------------------------------------
    always_comb begin
        ack_d   = bus_grant;
        err_d   = bus_req && !bus_ok && !cp_hit;
        bdat_d  = bdat_q;
        cpdat_d = cpdat_q;
        if (bus_grant && !we_i) begin
            bdat_d = read_word(adr_i, latch, dir, indata);
        end
        if (cp_hit && !cp_we_i) begin
            cpdat_d = read_word(cp_addr_i[7:0], latch, dir, indata);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            bdat_q  <= 32'h0000_0000;
            cpdat_q <= 32'h0000_0000;
        end else begin
            ack_q   <= ack_d;
            err_q   <= err_d;
            bdat_q  <= bdat_d;
            cpdat_q <= cpdat_d;
        end
    end

    assign ack_o      = ack_q;
    assign err_o      = err_q;
    assign dat_o      = bdat_q;
    assign cp_rdata_o = cpdat_q;
    assign cp_hit_o   = cp_hit;

    // --------------------------------------------------------
    // pin drive
    // --------------------------------------------------------
    assign pin_oe_o = gpio_func_i & dir;
    assign pin_o    = gpio_func_i & latch;
endmodule

// File: rtl/gpfp_pkg.sv
// constants for the gpio port with fast core-port alias
package gpfp_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses within a port window)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_OUT_LATCH = 8'h00;
    localparam logic [7:0] OFS_OUT_SET   = 8'h04;
    localparam logic [7:0] OFS_OUT_CLR   = 8'h08;
    localparam logic [7:0] OFS_OUT_TGL   = 8'h0C;
    localparam logic [7:0] OFS_IN_DATA   = 8'h10;
    localparam logic [7:0] OFS_DIR       = 8'h14;
    // ------------------------------------------------------------
    // reset values and core-port window
    // ------------------------------------------------------------
    localparam logic [31:0] RST_OUT_LATCH = 32'h0000_0000;
    localparam logic [31:0] RST_DIR       = 32'h0000_0000;
    localparam logic [31:0] RST_IN_DATA   = 32'h0000_0000;
    localparam logic [31:0] CORE_PORT_BASE = 32'hF800_0000;
    localparam logic [31:0] CORE_PORT_MASK = 32'hFFFF_FF00;
endpackage

// File: rtl/gpfp_regs.sv
// shared register core: one write port, latch, direction and input data output straight from their flops
`timescale 1ns/1ps
module gpfp_regs #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             we_i,
    input  wire logic [7:0]       ofs_i,
    input  wire logic [WIDTH-1:0] wdat_i,
    input  wire logic [WIDTH-1:0] pin_sync_i,
    input  wire logic [WIDTH-1:0] sample_en_i,
    output logic      [WIDTH-1:0] latch_o,
    output logic      [WIDTH-1:0] dir_o,
    output logic      [WIDTH-1:0] indata_o
);
    logic [WIDTH-1:0] latch_q, latch_d;
    logic [WIDTH-1:0] dir_q, dir_d;
    logic [WIDTH-1:0] in_q, in_d;

    // --------------------------------------------------------
    // next values of latch, direction and input data
    // --------------------------------------------------------
    always_comb begin
        latch_d = latch_q;
        dir_d   = dir_q;
        if (we_i) begin
            unique case (ofs_i)
                gpfp_pkg::OFS_OUT_LATCH: latch_d = wdat_i;
                gpfp_pkg::OFS_OUT_SET:   latch_d = latch_q | wdat_i;
                gpfp_pkg::OFS_OUT_CLR:   latch_d = latch_q & ~wdat_i;
                gpfp_pkg::OFS_OUT_TGL:   latch_d = latch_q ^ wdat_i;
                gpfp_pkg::OFS_DIR:       dir_d   = wdat_i;
                default: ;
            endcase
        end
        // per-bit freeze of input sampling
        in_d = (pin_sync_i & sample_en_i) | (in_q & ~sample_en_i);
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= gpfp_pkg::RST_OUT_LATCH[WIDTH-1:0];
            dir_q   <= gpfp_pkg::RST_DIR[WIDTH-1:0];
            in_q    <= gpfp_pkg::RST_IN_DATA[WIDTH-1:0];
        end else begin
            latch_q <= latch_d;
            dir_q   <= dir_d;
            in_q    <= in_d;
        end
    end

    assign latch_o  = latch_q;
    assign dir_o    = dir_q;
    assign indata_o = in_q;
endmodule

// File: sim/gpfp_port_sva.sv
// assertions on the gpio port top pins
`timescale 1ns/1ps
module gpfp_port_sva #(
    parameter int WIDTH = 32
) (
    input wire logic             clk_i, rst_i, cyc_i, stb_i, ack_o, err_o,
    input wire logic             cp_sel_i, cp_we_i, cp_hit_o, compute_only_i,
    input wire logic [31:0]      cp_addr_i, cp_wdata_i, cp_rdata_o,
    input wire logic [WIDTH-1:0] gpio_func_i, pin_o, pin_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_gpio_only: assert property (((pin_o | pin_oe_o) & ~gpio_func_i) == '0)
        else $error("pin driven outside gpio select");
    a_hit_decode: assert property (cp_hit_o == (cp_sel_i && cp_addr_i[31:8] == 24'hF8_0000))
        else $error("core window decode wrong");
    a_cp_set: assert property (cp_hit_o && cp_we_i && cp_addr_i[7:0] == 8'h04 && &gpio_func_i
        ##1 &gpio_func_i |-> (pin_o & $past(cp_wdata_i)) == $past(cp_wdata_i))
        else $error("set port missed bits");
    a_cp_clr: assert property (cp_hit_o && cp_we_i && cp_addr_i[7:0] == 8'h08 && &gpio_func_i
        ##1 &gpio_func_i |-> (pin_o & $past(cp_wdata_i)) == '0)
        else $error("clear port missed bits");
    a_cp_tgl: assert property (cp_hit_o && cp_we_i && cp_addr_i[7:0] == 8'h0C && &gpio_func_i
        ##1 &gpio_func_i |-> (pin_o ^ $past(pin_o)) == $past(cp_wdata_i))
        else $error("toggle port wrong");
    a_wo_zero: assert property (cp_hit_o && !cp_we_i && cp_addr_i[7:0] inside {8'h04, 8'h08, 8'h0C}
        |=> cp_rdata_o == '0)
        else $error("write-only port read nonzero");
    a_bus_yield: assert property (cp_hit_o |=> !(ack_o || err_o))
        else $error("bus answered during core access");
    a_bus_bound: assert property (cyc_i && stb_i && !ack_o && !err_o |-> ##[1:8] (ack_o || err_o))
        else $error("bus access never answered");
    a_co_noack: assert property (compute_only_i && cyc_i && stb_i && !ack_o && !err_o |=> !ack_o)
        else $error("bus acked in compute-only");
endmodule
bind gpfp_port gpfp_port_sva #(.WIDTH(WIDTH)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .cp_sel_i(cp_sel_i),
    .cp_we_i(cp_we_i), .cp_hit_o(cp_hit_o), .compute_only_i(compute_only_i),
    .cp_addr_i(cp_addr_i), .cp_wdata_i(cp_wdata_i), .cp_rdata_o(cp_rdata_o),
    .gpio_func_i(gpio_func_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));

// File: sim/gpfp_core_model.sv
// core-port master model: one access per call, read data a cycle later
`timescale 1ns/1ps
module gpfp_core_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] cp_rdata_i,
    output logic             cp_sel_o = 1'b0,
    output logic             cp_we_o = 1'b0,
    output logic      [31:0] cp_addr_o = 32'h0,
    output logic      [31:0] cp_wdata_o = 32'h0
);
    // drive one cycle, then drop select and scramble address and data; write enable keeps its value
    task automatic acc(input logic w, input logic [7:0] o, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        cp_sel_o <= 1'b1;
        cp_we_o <= w;
        cp_addr_o <= {24'hF8_0000, o};
        cp_wdata_o <= d;
        @(posedge clk_i);
        cp_sel_o <= 1'b0;
        cp_addr_o <= {24'h07_FFFF, ~o};
        cp_wdata_o <= ~d;
        @(posedge clk_i);
        q = cp_rdata_i;
    endtask
endmodule

// File: sim/gpfp_port_tb_top.sv
// self-checking bench for the gpio port with core-port alias
`timescale 1ns/1ps
module gpfp_port_tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h0;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, pin_i = 32'h0, gpio_func_i = 32'h0, q;
    logic compute_only_i = 1'b0, port_ctrl_en_i = 1'b1, e;
    logic ack_o, err_o, cp_sel_i, cp_we_i, cp_hit_o;
    logic [31:0] dat_o, cp_addr_i, cp_wdata_i, cp_rdata_o, pin_o, pin_oe_o;
    int n_mismatch = 0, samples_checked = 0;
    always #5 clk_i = ~clk_i;
    gpfp_port u_gpfp_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .err_o(err_o), .cp_sel_i(cp_sel_i), .cp_we_i(cp_we_i),
        .cp_addr_i(cp_addr_i), .cp_wdata_i(cp_wdata_i), .cp_rdata_o(cp_rdata_o),
        .cp_hit_o(cp_hit_o), .compute_only_i(compute_only_i), .port_ctrl_en_i(port_ctrl_en_i),
        .gpio_func_i(gpio_func_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
    gpfp_core_model u_gpfp_core_model (.clk_i(clk_i), .cp_rdata_i(cp_rdata_o),
        .cp_sel_o(cp_sel_i), .cp_we_o(cp_we_i), .cp_addr_o(cp_addr_i), .cp_wdata_o(cp_wdata_i));
    // compare tasks
    task automatic chk32(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic chk1(input logic g, input logic x);
        samples_checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("unexpected at %0t: error flag %b", $time, g);
        end
    endtask
    // classic wishbone cycle, held until ack or err
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 40);
        q = dat_o;
        e = err_o;
        if (n >= 40) begin
            n_mismatch++;
            $display("unexpected at %0t: bus hang", $time);
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        adr_i <= ~a;
        dat_i <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        chk1(e, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        wb(1'b0, a, 32'h0);
        chk1(e, 1'b0);
        chk32(q, x);
    endtask
    task automatic rderr(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
        chk1(e, 1'b1);
    endtask
    task automatic cwr(input logic [7:0] a, input logic [31:0] d);
        u_gpfp_core_model.acc(1'b1, a, d, q);
    endtask
    task automatic crd(input logic [7:0] a, input logic [31:0] x);
        u_gpfp_core_model.acc(1'b0, a, 32'h0, q);
        chk32(q, x);
    endtask
    task automatic wrap_up;
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (3000) @(posedge clk_i);
        n_mismatch++;
        wrap_up();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        chk32(pin_oe_o, 32'h0);
        gpio_func_i <= 32'hFFFF_FFFF;
        wr(8'h14, 32'hFFFF_0000);
        chk32(pin_oe_o, 32'hFFFF_0000);
        wr(8'h00, 32'h1234_5678);
        chk32(pin_o, 32'h1234_5678);
        crd(8'h00, 32'h1234_5678);
        cwr(8'h04, 32'h0000_000F);
        cwr(8'h08, 32'h0000_00F0);
        cwr(8'h0C, 32'hFF00_0000);
        rd(8'h00, 32'hED34_560F);
        rd(8'h04, 32'h0);
        crd(8'h0C, 32'h0);
        port_ctrl_en_i <= 1'b0;
        wr(8'h14, 32'hFFFF_FFFF);
        chk32(pin_oe_o, 32'hFFFF_FFFF);
        port_ctrl_en_i <= 1'b1;
        pin_i <= 32'h5A5A_5A5A;
        repeat (5) @(posedge clk_i);
        rd(8'h10, 32'h5A5A_5A5A);
        port_ctrl_en_i <= 1'b0;
        pin_i <= 32'hA5A5_A5A5;
        repeat (5) @(posedge clk_i);
        rd(8'h10, 32'h5A5A_5A5A);
        port_ctrl_en_i <= 1'b1;
        compute_only_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        crd(8'h10, 32'h5A5A_5A5A);
        rderr(8'h00);
        cwr(8'h00, 32'h0000_1111);
        crd(8'h00, 32'h0000_1111);
        compute_only_i <= 1'b0;
        rderr(8'h20);
        repeat (5) @(posedge clk_i);
        rd(8'h10, 32'hA5A5_A5A5);
        fork
            wr(8'h00, 32'h0);
            cwr(8'h04, 32'h0000_0001);
        join
        rd(8'h00, 32'h0);
        gpio_func_i <= 32'h0;
        @(posedge clk_i);
        chk32(pin_o | pin_oe_o, 32'h0);
        wrap_up();
    end
endmodule
